// ===== src/ibuf_top.sv
// Purpose: handoff logic for isochronous x/y endpoint buffers
// Assumes: usb engine and dma data paths live outside this block
// Notes:   one register port, results one cycle after events
//
// Added by the designer: the placing of the registers and strobed register access.
`include "ibuf_defines.svh"

module ibuf_top #(
  parameter int NUM_DMA = 4,   // dma channels
  parameter int NUM_EP  = 8    // endpoint slots per direction
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_i,
  // register port
  input  wire logic [7:0]             addr_i,
  input  wire logic [7:0]             wr_data_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic [7:0]                  rd_data_o,
  // frame timing
  input  wire logic                   frame_start_i,
  input  wire logic                   pseudo_frame_start_i,
  input  wire logic [10:0]            frame_num_i,
  // usb out packet finished
  input  wire logic                   out_done_i,
  input  wire logic [2:0]             out_ep_i,
  input  wire logic [9:0]             out_len_i,
  // usb in token and its end
  input  wire logic                   in_token_i,
  input  wire logic [2:0]             in_ep_i,
  input  wire logic                   in_done_i,
  // usb answers
  output logic                        in_ack_o,
  output logic                        in_zero_o,
  output logic [9:0]                  in_len_o,
  output logic                        in_sel_y_o,
  output logic                        usb_sel_y_o,
  // codec samples per in channel, dma start per out channel
  input  wire logic [NUM_DMA-1:0]     codec_sample_i,
  output logic [NUM_DMA-1:0]          dma_go_o,
  output logic [NUM_DMA*10-1:0]       dma_len_o
);

  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  ibuf_pkg::ibuf_byte_t cfg_reg   [2*NUM_EP]; // config bytes
  ibuf_pkg::ibuf_byte_t xsize_reg [2*NUM_EP]; // x size in bytes
  ibuf_pkg::ibuf_byte_t ysize_reg [2*NUM_EP]; // y size in bytes
  ibuf_pkg::ibuf_byte_t xcnt_reg  [2*NUM_EP]; // x sample count
  ibuf_pkg::ibuf_byte_t ycnt_reg  [2*NUM_EP]; // y sample count
  logic                 xflag_reg [2*NUM_EP]; // x handoff_flag
  logic                 yflag_reg [2*NUM_EP]; // y handoff_flag
  ibuf_pkg::ibuf_byte_t dma_reg   [NUM_DMA];  // channel binding
  ibuf_pkg::ibuf_byte_t acc_reg   [NUM_DMA];  // in samples so far
  logic                 cur_y_reg;            // usb side on y
  logic                 in_y_reg;             // buffer of open token
  ibuf_pkg::ibuf_idx_t  in_idx_reg;           // endpoint of token
  logic                 in_busy_reg;          // token outstanding
  ibuf_pkg::ibuf_idx_t  ch_idx  [NUM_DMA];    // bound endpoint
  logic                 ch_in   [NUM_DMA];    // live in channel
  logic                 ch_out  [NUM_DMA];    // live out channel
  logic                 in_full [NUM_DMA];    // next sample won't fit

  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  ibuf_pkg::ibuf_idx_t a_idx;     // addressed endpoint
  logic [2:0]          a_reg;     // addressed register
  logic                sof;       // any frame start
  ibuf_pkg::ibuf_idx_t o_idx;     // out packet endpoint
  ibuf_pkg::ibuf_idx_t t_idx;     // in token endpoint
  logic                dma_slot;  // access to channel slot

  assign a_idx    = addr_i[7:4];
  assign a_reg    = addr_i[2:0];
  assign sof      = frame_start_i | pseudo_frame_start_i;
  assign o_idx    = {1'b0, out_ep_i};
  assign t_idx    = {1'b1, in_ep_i};
  assign dma_slot = (a_idx == 4'h0);

  // bytes per sample, code 0..3 means 1..4 bytes
  function automatic logic [2:0] bps(input logic [7:0] c);
    bps = {1'b0, c[`IBUF_CFG_BPS_LO+1:`IBUF_CFG_BPS_LO]} + 3'h1;
  endfunction

  // endpoint live: enabled, typed isochronous, not endpoint 0
  function automatic logic live(input logic [7:0] c,
                                input logic [2:0] ep);
    live = c[`IBUF_CFG_EN] & c[`IBUF_CFG_ISO] & (ep != 3'h0);
  endfunction

  // -----------------------------------------------------------------
  // out packet arithmetic
  // -----------------------------------------------------------------
  logic [7:0] o_size;   // size of the buffer being written
  logic       o_ovf;    // packet longer than buffer
  logic [9:0] o_keep;   // bytes actually kept
  logic [7:0] o_samp;   // samples kept
  always_comb begin
    // usb writes x on even frames, y on odd
    o_size = cur_y_reg ? ysize_reg[o_idx] : xsize_reg[o_idx];
    o_ovf  = out_len_i > {2'h0, o_size};
    o_keep = o_ovf ? {2'h0, o_size} : out_len_i;
    // samples, not bytes, go into the count byte
    o_samp = 8'(o_keep / {7'h0, bps(cfg_reg[o_idx])});
  end

  // -----------------------------------------------------------------
  // frame parity: buffer the usb side works on
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cur_y_reg <= 1'b0;
    end else if (sof) begin
      // lsb 0 picks x, so the far side always has the other one
      cur_y_reg <= frame_num_i[0];
    end
  end

  // -----------------------------------------------------------------
  // in token tracking and answer
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      in_ack_o    <= 1'b0;
      in_zero_o   <= 1'b0;
      in_len_o    <= 10'h000;
      in_sel_y_o  <= 1'b0;
      in_y_reg    <= 1'b0;
      in_idx_reg  <= 4'h0;
      in_busy_reg <= 1'b0;
    end else begin
      in_ack_o <= 1'b0;
      if (in_done_i) begin
        in_busy_reg <= 1'b0;
      end
      if (in_token_i && live(cfg_reg[t_idx], in_ep_i)) begin
        in_ack_o   <= 1'b1;
        in_sel_y_o <= cur_y_reg;
        in_idx_reg <= t_idx;
        in_y_reg   <= cur_y_reg;
        if (cur_y_reg ? yflag_reg[t_idx] : xflag_reg[t_idx]) begin
          // nothing new from the filler: empty data packet
          in_zero_o   <= 1'b1;
          in_len_o    <= 10'h000;
          in_busy_reg <= 1'b0;
        end else begin
          in_zero_o   <= 1'b0;
          // widen both factors first: 255 samples of 4 bytes
          in_len_o    <= {2'h0, (cur_y_reg ? ycnt_reg[t_idx]
                                           : xcnt_reg[t_idx])} *
                         {7'h0, bps(cfg_reg[t_idx])};
          in_busy_reg <= 1'b1;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // configuration, sizes, channel bindings
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < 2*NUM_EP; i++) begin
        cfg_reg[i]   <= `IBUF_RESET_BYTE;
        xsize_reg[i] <= `IBUF_RESET_BYTE;
        ysize_reg[i] <= `IBUF_RESET_BYTE;
      end
      for (int c = 0; c < NUM_DMA; c++) begin
        dma_reg[c] <= `IBUF_RESET_BYTE;
      end
    end else begin
      if (wr_i && dma_slot && a_reg < 3'(NUM_DMA)) begin
        // one endpoint per channel, firmware keeps them distinct
        dma_reg[a_reg[1:0]] <= wr_data_i;
      end else if (wr_i && !dma_slot) begin
        unique case (a_reg)
          `IBUF_REG_CFG:   cfg_reg[a_idx]   <= wr_data_i;
          `IBUF_REG_XSIZE: xsize_reg[a_idx] <= wr_data_i;
          `IBUF_REG_YSIZE: ysize_reg[a_idx] <= wr_data_i;
          default: ;  // counts and flags live elsewhere
        endcase
      end
      // overflow is sticky; hardware set follows the write
      if (out_done_i && live(cfg_reg[o_idx], out_ep_i) && o_ovf) begin
        cfg_reg[o_idx][`IBUF_CFG_OVF] <= 1'b1;
      end
      for (int c = 0; c < NUM_DMA; c++) begin
        if (codec_sample_i[c] && in_full[c]) begin
          cfg_reg[ch_idx[c]][`IBUF_CFG_OVF] <= 1'b1;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // channel views
  // -----------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NUM_DMA; c++) begin
      ch_idx[c] = {dma_reg[c][`IBUF_DMA_DIR], dma_reg[c][2:0]};
      // an endpoint with no bound channel is left to firmware
      ch_in[c]  = dma_reg[c][`IBUF_DMA_EN] & ch_idx[c][3] &
                  live(cfg_reg[ch_idx[c]], ch_idx[c][2:0]);
      ch_out[c] = dma_reg[c][`IBUF_DMA_EN] & ~ch_idx[c][3] &
                  live(cfg_reg[ch_idx[c]], ch_idx[c][2:0]);
      // dma fills the buffer the usb side is not on
      in_full[c] = ch_in[c] &
        ({2'h0, acc_reg[c]} + 10'h001) * 10'(bps(cfg_reg[ch_idx[c]]))
        > {2'h0, cur_y_reg ? xsize_reg[ch_idx[c]]
                           : ysize_reg[ch_idx[c]]};
    end
  end

  // -----------------------------------------------------------------
  // in-direction sample accumulation over the frame
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      for (int c = 0; c < NUM_DMA; c++) begin
        acc_reg[c] <= 8'h00;
      end
    end else begin
      for (int c = 0; c < NUM_DMA; c++) begin
        if (sof) begin
          acc_reg[c] <= 8'h00; // count handed off at frame end
        end else if (codec_sample_i[c] && ch_in[c] && !in_full[c]) begin
          acc_reg[c] <= acc_reg[c] + 8'h01;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // out-direction dma start pulses
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      dma_go_o  <= '0;
      dma_len_o <= '0;
    end else begin
      for (int c = 0; c < NUM_DMA; c++) begin
        // the buffer usb wrote last frame, now idle for usb
        dma_go_o[c] <= sof & ch_out[c] &
          (cur_y_reg ? yflag_reg[ch_idx[c]]
                     : xflag_reg[ch_idx[c]]);
        if (sof && ch_out[c]) begin
          dma_len_o[c*10 +: 10] <= {2'h0, (cur_y_reg
            ? ycnt_reg[ch_idx[c]] : xcnt_reg[ch_idx[c]])} *
            {7'h0, bps(cfg_reg[ch_idx[c]])};
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // descriptors: counts and handoff flags
  // software first, hardware after, so a hardware update wins over a firmware write
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < 2*NUM_EP; i++) begin
        xcnt_reg[i]  <= 8'h00;
        ycnt_reg[i]  <= 8'h00;
        xflag_reg[i] <= 1'b0;
        yflag_reg[i] <= 1'b0;
      end
    end else begin
      if (wr_i && !dma_slot) begin
        unique case (a_reg)
          `IBUF_REG_XCNT:  xcnt_reg[a_idx] <= wr_data_i;
          `IBUF_REG_YCNT:  ycnt_reg[a_idx] <= wr_data_i;
          `IBUF_REG_FLAGS: begin
            // firmware hands buffers over by writing flags
            xflag_reg[a_idx] <= wr_data_i[`IBUF_FLG_X];
            yflag_reg[a_idx] <= wr_data_i[`IBUF_FLG_Y];
          end
          default: ;
        endcase
      end
      // out dma takes the buffer and clears its flag
      for (int c = 0; c < NUM_DMA; c++) begin
        if (sof && ch_out[c]) begin
          if (cur_y_reg) yflag_reg[ch_idx[c]] <= 1'b0;
          else           xflag_reg[ch_idx[c]] <= 1'b0;
        end
        // in dma: count written and flag cleared together
        if (sof && ch_in[c]) begin
          if (cur_y_reg) begin
            xcnt_reg[ch_idx[c]]  <= acc_reg[c];
            xflag_reg[ch_idx[c]] <= 1'b0;
          end else begin
            ycnt_reg[ch_idx[c]]  <= acc_reg[c];
            yflag_reg[ch_idx[c]] <= 1'b0;
          end
        end
      end
      // usb out packet stored: count and set, no interrupt
      if (out_done_i && live(cfg_reg[o_idx], out_ep_i)) begin
        if (cur_y_reg) begin
          ycnt_reg[o_idx]  <= o_samp;
          yflag_reg[o_idx] <= 1'b1;
        end else begin
          xcnt_reg[o_idx]  <= o_samp;
          xflag_reg[o_idx] <= 1'b1;
        end
      end
      // in transaction over: buffer back to the filler
      if (in_done_i && in_busy_reg) begin
        if (in_y_reg) yflag_reg[in_idx_reg] <= 1'b1;
        else          xflag_reg[in_idx_reg] <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // read data, one cycle after the strobe, zero otherwise
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_data_o <= 8'h00;
    end else if (!rd_i) begin
      rd_data_o <= 8'h00;
    end else if (dma_slot) begin
      if (a_reg < 3'(NUM_DMA)) rd_data_o <= dma_reg[a_reg[1:0]];
      else if (a_reg == `IBUF_REG_FRAME)
        rd_data_o <= {7'h00, cur_y_reg}; // usb side parity
      else rd_data_o <= 8'h00;
    end else begin
      unique case (a_reg)
        `IBUF_REG_CFG:   rd_data_o <= cfg_reg[a_idx];
        `IBUF_REG_XSIZE: rd_data_o <= xsize_reg[a_idx];
        `IBUF_REG_YSIZE: rd_data_o <= ysize_reg[a_idx];
        `IBUF_REG_XCNT:  rd_data_o <= xcnt_reg[a_idx];
        `IBUF_REG_YCNT:  rd_data_o <= ycnt_reg[a_idx];
        `IBUF_REG_FLAGS: rd_data_o <= {6'h00, yflag_reg[a_idx],
                                       xflag_reg[a_idx]};
        default:         rd_data_o <= 8'h00; // unmapped
      endcase
    end
  end

  assign usb_sel_y_o = cur_y_reg;

endmodule

// ===== src/ibuf_defines.svh
// Purpose: constants of the isochronous double buffer block
// Assumes: byte-wide register file, index = {dir, ep, reg}
// Notes:   a count above the buffer size sets the overflow bit
`ifndef IBUF_DEFINES_SVH
`define IBUF_DEFINES_SVH

// -----------------------------------------------------------------
// register index within an endpoint slot
// -----------------------------------------------------------------
`define IBUF_REG_CFG    3'h0
`define IBUF_REG_XSIZE  3'h1
`define IBUF_REG_YSIZE  3'h2
`define IBUF_REG_XCNT   3'h3
`define IBUF_REG_YCNT   3'h4
`define IBUF_REG_FLAGS  3'h5
// endpoint 0 slot of the out side holds the dma channels
`define IBUF_REG_FRAME  3'h4

// -----------------------------------------------------------------
// configuration byte fields
// -----------------------------------------------------------------
`define IBUF_CFG_EN     0
`define IBUF_CFG_ISO    1
`define IBUF_CFG_BPS_LO 2
`define IBUF_CFG_OVF    7
// dma channel byte: enable, direction in, endpoint number
`define IBUF_DMA_EN     7
`define IBUF_DMA_DIR    3
// flags byte
`define IBUF_FLG_X      0
`define IBUF_FLG_Y      1

`define IBUF_RESET_BYTE 8'h00
`endif

// ===== src/ibuf_pkg.sv
// Purpose: shared types of the isochronous double buffer block
// Assumes: ibuf_defines.svh holds the numbers
// Notes:   index is {dir, ep}, dir 1 means in endpoint
package ibuf_pkg;
  typedef logic [3:0] ibuf_idx_t;   // {dir, ep}
  typedef logic [7:0] ibuf_byte_t;  // register byte
  typedef logic [9:0] ibuf_len_t;   // byte length
endpackage

// ===== tb/ibuf_top_assertions.sv
// Purpose: port-level checks of the iso endpoint handoff block
// Assumes: one clock, synchronous active high reset
// Notes:   bound to ibuf_top, sees its ports only
module ibuf_top_checker #(
  parameter int NUM_DMA = 4  // dma channels
) (
  input wire logic                 ref_clk_i,
  input wire logic                 reset_i,
  input wire logic                 rd_i,
  input wire logic [7:0]           rd_data_o,
  input wire logic                 frame_start_i,
  input wire logic                 pseudo_frame_start_i,
  input wire logic [10:0]          frame_num_i,
  input wire logic                 in_token_i,
  input wire logic                 in_ack_o,
  input wire logic                 in_zero_o,
  input wire logic [9:0]           in_len_o,
  input wire logic                 in_sel_y_o,
  input wire logic                 usb_sel_y_o,
  input wire logic [NUM_DMA-1:0]   dma_go_o,
  input wire logic [NUM_DMA*10-1:0] dma_len_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  logic fs;  // either kind of frame start
  assign fs = frame_start_i | pseudo_frame_start_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  // read data only in the slot after the strobe
  a_read_idle: assert property (!rd_i |=> rd_data_o == 8'h00)
    else $error("read data outside its slot");
  a_ack_cause: assert property (in_ack_o |-> $past(in_token_i))
    else $error("answer without a token");
  a_zero_empty: assert property (in_zero_o |-> in_len_o == 10'h000)
    else $error("empty answer with a length");
  a_zero_on_ack: assert property ($rose(in_zero_o) |-> in_ack_o)
    else $error("empty flag moved without answer");
  a_len_holds: assert property (!in_ack_o |->
    $stable(in_len_o) && $stable(in_sel_y_o))
    else $error("answer changed without token");
  a_go_on_frame: assert property (|dma_go_o |-> $past(fs))
    else $error("stream start outside frame start");
  a_sel_frame: assert property (fs |=>
    usb_sel_y_o == $past(frame_num_i[0]))
    else $error("buffer select not from frame lsb");
  a_sel_steady: assert property (!fs |=> $stable(usb_sel_y_o))
    else $error("buffer select moved mid frame");
  a_dma_len_hold: assert property (!fs |=> $stable(dma_len_o))
    else $error("stream length moved mid frame");
  cv_zero: cover property (in_ack_o && in_zero_o);
  cv_data: cover property (in_ack_o && !in_zero_o);
  cv_go: cover property (|dma_go_o);
endmodule

bind ibuf_top ibuf_top_checker #(.NUM_DMA(NUM_DMA)) u_chk (
  .ref_clk_i, .reset_i, .rd_i, .rd_data_o, .frame_start_i,
  .pseudo_frame_start_i, .frame_num_i, .in_token_i, .in_ack_o,
  .in_zero_o, .in_len_o, .in_sel_y_o, .usb_sel_y_o, .dma_go_o,
  .dma_len_o);

// ===== tb/ibuf_host_model.sv
// Purpose: usb host engine and codec sample source facing the block
// Assumes: strobes are one cycle, driven just after a rising edge
// Notes:   qualifiers are scrambled once their strobe has gone
module ibuf_host_model (
  input  wire logic        ref_clk_i,
  output logic             frame_start_o,
  output logic             pseudo_frame_start_o,
  output logic [10:0]      frame_num_o,
  output logic             out_done_o,
  output logic [2:0]       out_ep_o,
  output logic [9:0]       out_len_o,
  output logic             in_token_o,
  output logic [2:0]       in_ep_o,
  output logic             in_done_o,
  output logic [3:0]       codec_sample_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------------------------------
  // idle levels
  // -----------------------------------------------------------------
  initial begin
    {frame_start_o, pseudo_frame_start_o, out_done_o} = 3'h0;
    {in_token_o, in_done_o, codec_sample_o} = 6'h00;
    {frame_num_o, out_ep_o, out_len_o, in_ep_o} = 27'h0;
  end
  // frame start, real or pseudo
  task frame(input logic [10:0] n, input logic ps);
    @(posedge ref_clk_i);
    frame_num_o <= n;
    frame_start_o <= !ps;
    pseudo_frame_start_o <= ps;
    @(posedge ref_clk_i);
    {frame_start_o, pseudo_frame_start_o} <= 2'h0;
    frame_num_o <= ~n;  // number not held past the strobe
  endtask
  // out packet stored by the usb engine
  task send_out(input logic [2:0] ep, input logic [9:0] len);
    @(posedge ref_clk_i);
    {out_done_o, out_ep_o, out_len_o} <= {1'b1, ep, len};
    @(posedge ref_clk_i);
    {out_done_o, out_ep_o, out_len_o} <= {1'b0, ~ep, ~len};
  endtask
  // in token; the end comes later, never with it
  task token(input logic [2:0] ep);
    @(posedge ref_clk_i);
    {in_token_o, in_ep_o} <= {1'b1, ep};
    @(posedge ref_clk_i);
    {in_token_o, in_ep_o} <= {1'b0, ~ep};
  endtask
  task finish_in;
    @(posedge ref_clk_i);
    in_done_o <= 1'b1;
    @(posedge ref_clk_i);
    in_done_o <= 1'b0;
  endtask
  // codec samples for one in channel, spread over the frame
  task samples(input int ch, input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      codec_sample_o <= 4'h1 << ch;
      @(posedge ref_clk_i);
      codec_sample_o <= 4'h0;
    end
  endtask
endmodule

// ===== tb/tb_iso_endpoint_double_buffer.sv
// Purpose: self-checking bench of the iso endpoint handoff block
// Assumes: host model drives the usb and codec side
// Notes:   frame parity decides which buffer each side owns
`include "ibuf_defines.svh"
module tb_iso_endpoint_double_buffer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i, reset_i, wr_i, rd_i;
  logic [7:0]  addr_i, wr_data_i, rd_data_o;
  logic        frame_start_i, pseudo_frame_start_i, out_done_i;
  logic        in_token_i, in_done_i, in_ack_o, in_zero_o;
  logic        in_sel_y_o, usb_sel_y_o;
  logic [10:0] frame_num_i;
  logic [2:0]  out_ep_i, in_ep_i;
  logic [9:0]  out_len_i, in_len_o;
  logic [3:0]  codec_sample_i, dma_go_o;
  logic [39:0] dma_len_o;
  int          failures, checked;
  ibuf_top DUT (.ref_clk_i, .reset_i, .addr_i, .wr_data_i, .wr_i, .rd_i,
    .rd_data_o, .frame_start_i, .pseudo_frame_start_i, .frame_num_i,
    .out_done_i, .out_ep_i, .out_len_i, .in_token_i, .in_ep_i,
    .in_done_i, .in_ack_o, .in_zero_o, .in_len_o, .in_sel_y_o,
    .usb_sel_y_o, .codec_sample_i, .dma_go_o, .dma_len_o);
  ibuf_host_model host (.ref_clk_i, .frame_start_o(frame_start_i),
    .pseudo_frame_start_o(pseudo_frame_start_i), .frame_num_o(frame_num_i),
    .out_done_o(out_done_i), .out_ep_o(out_ep_i), .out_len_o(out_len_i),
    .in_token_o(in_token_i), .in_ep_o(in_ep_i), .in_done_o(in_done_i),
    .codec_sample_o(codec_sample_i));
  // -----------------------------------------------------------------
  // bus and compare helpers
  // -----------------------------------------------------------------
  function automatic logic [7:0] ad(logic d, logic [2:0] e, logic [2:0] r);
    return {d, e, 1'b0, r};
  endfunction
  task chk(string n, logic [9:0] e, logic [9:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk_i);
    {addr_i, wr_data_i, wr_i} <= {a, d, 1'b1};
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task rdc(string n, logic [7:0] a, logic [7:0] e);
    @(posedge ref_clk_i);
    {addr_i, rd_i} <= {a, 1'b1};
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(n, {2'h0, e}, {2'h0, rd_data_o});
  endtask
  task fr(logic [10:0] n, logic ps, logic [3:0] go);
    host.frame(n, ps);
    #1;
    chk("go", {6'h0, go}, {6'h0, dma_go_o});
    chk("usb_sel", {9'h0, n[0]}, {9'h0, usb_sel_y_o});
  endtask
  task tok(logic [2:0] ep, logic ack, logic z, logic [9:0] len, logic y);
    host.token(ep);
    #1;
    chk("ack", {9'h0, ack}, {9'h0, in_ack_o});
    if (ack) begin
      chk("zero", {9'h0, z}, {9'h0, in_zero_o});
      chk("len", len, in_len_o);
      chk("sel", {9'h0, y}, {9'h0, in_sel_y_o});
    end
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task t_regs;  // reset values, in slots 1 to 7 reachable
    rdc("cfg", ad(0, 3'h1, `IBUF_REG_CFG), 8'h00);
    rdc("flags", ad(1, 3'h1, `IBUF_REG_FLAGS), 8'h00);
    rdc("unmapped", ad(0, 3'h1, 3'h7), 8'h00);
    for (int e = 1; e < 8; e++) begin
      wr(ad(1, 3'(e), `IBUF_REG_YSIZE), 8'(e * 5));
      rdc("ysize", ad(1, 3'(e), `IBUF_REG_YSIZE), 8'(e * 5));
    end
  endtask
  task t_out;  // out ep 2, two bytes a sample, 64 byte buffers
    wr(ad(0, 3'h2, `IBUF_REG_CFG), 8'h07);
    wr(ad(0, 3'h2, `IBUF_REG_XSIZE), 8'h40);
    wr(ad(0, 3'h2, `IBUF_REG_YSIZE), 8'h40);
    fr(11'h002, 1'b0, 4'h0);
    host.send_out(3'h2, 10'd20);
    rdc("xcnt", ad(0, 3'h2, `IBUF_REG_XCNT), 8'h0a);
    rdc("flags", ad(0, 3'h2, `IBUF_REG_FLAGS), 8'h01);
    fr(11'h003, 1'b0, 4'h0);
    rdc("frame", 8'h04, 8'h01);
    host.send_out(3'h2, 10'd100);  // too long for the buffer
    rdc("ycnt", ad(0, 3'h2, `IBUF_REG_YCNT), 8'h20);
    rdc("flags", ad(0, 3'h2, `IBUF_REG_FLAGS), 8'h03);
    rdc("ovf", ad(0, 3'h2, `IBUF_REG_CFG), 8'h87);
    wr(ad(0, 3'h2, `IBUF_REG_CFG), 8'h07);
    rdc("cfg", ad(0, 3'h2, `IBUF_REG_CFG), 8'h07);
  endtask
  task t_dma_out;  // channel 0 streams out ep 2
    wr(8'h00, 8'h82);
    fr(11'h004, 1'b0, 4'h1);
    chk("len0", 10'd64, dma_len_o[9:0]);
    rdc("flags", ad(0, 3'h2, `IBUF_REG_FLAGS), 8'h01);
    fr(11'h005, 1'b1, 4'h1);
    chk("len0", 10'd20, dma_len_o[9:0]);
    rdc("flags", ad(0, 3'h2, `IBUF_REG_FLAGS), 8'h00);
    fr(11'h006, 1'b0, 4'h0);
    // channel unbound: firmware now serves out ep 2 itself
    wr(8'h00, 8'h00);
    host.send_out(3'h2, 10'd8);  // four samples into x
    fr(11'h009, 1'b1, 4'h0);
    rdc("frame", 8'h04, 8'h01);
    rdc("flags", ad(0, 3'h2, `IBUF_REG_FLAGS), 8'h01);
    rdc("xcnt", ad(0, 3'h2, `IBUF_REG_XCNT), 8'h04);
    wr(ad(0, 3'h2, `IBUF_REG_FLAGS), 8'h00);
    rdc("flags", ad(0, 3'h2, `IBUF_REG_FLAGS), 8'h00);
    fr(11'h00a, 1'b0, 4'h0);
  endtask
  task t_in;  // in ep 3 fed by channel 1, one byte a sample
    wr(ad(1, 3'h3, `IBUF_REG_CFG), 8'h03);
    wr(ad(1, 3'h3, `IBUF_REG_XSIZE), 8'h08);
    wr(ad(1, 3'h3, `IBUF_REG_YSIZE), 8'h08);
    wr(ad(1, 3'h3, `IBUF_REG_FLAGS), 8'h03);
    wr(8'h01, 8'h8b);
    tok(3'h3, 1'b1, 1'b1, 10'd0, 1'b0);
    tok(3'h5, 1'b0, 1'b0, 10'd0, 1'b0);
    host.samples(1, 5);
    fr(11'h007, 1'b0, 4'h0);
    rdc("ycnt", ad(1, 3'h3, `IBUF_REG_YCNT), 8'h05);
    rdc("flags", ad(1, 3'h3, `IBUF_REG_FLAGS), 8'h01);
    tok(3'h3, 1'b1, 1'b0, 10'd5, 1'b1);
    host.finish_in();
    rdc("flags", ad(1, 3'h3, `IBUF_REG_FLAGS), 8'h03);
    host.samples(1, 10);  // two more than the buffer holds
    fr(11'h008, 1'b0, 4'h0);
    rdc("ovf", ad(1, 3'h3, `IBUF_REG_CFG), 8'h83);
    tok(3'h3, 1'b1, 1'b0, 10'd8, 1'b0);
  endtask
  // -----------------------------------------------------------------
  // run control
  // -----------------------------------------------------------------
  task close_out;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // watchdog: the scenarios need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    failures++;
    close_out();
  end
  initial begin
    {reset_i, wr_i, rd_i, addr_i, wr_data_i} = {3'h4, 16'h0000};
    {failures, checked} = {32'd0, 32'd0};
    repeat (6) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_out();
    t_dma_out();
    t_in();
    close_out();
  end
endmodule
